/* core/fmia_id_cmp.v */
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------
// Registered 128-bit authentication compare
// -----------------------------------------------------------------
module fmia_id_cmp #(
   parameter ID_W = 128
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Compare operands
   input wire [ID_W-1:0] entered_id,
   input wire [ID_W-1:0] stored_id,
   // Result, 1 means mismatch
   output reg mismatch_reg
);
   // Compare each cycle so any write shows one cycle later
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mismatch_reg <= 1'b0;
      end else begin
         mismatch_reg <= (entered_id != stored_id);
      end
   end
endmodule // fmia_id_cmp
`default_nettype wire

/* core/fmia_map.vh */
`ifndef FMIA_MAP_VH
`define FMIA_MAP_VH
// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define FMIA_OFF_ID0 12'h000
`define FMIA_OFF_ID1 12'h004
`define FMIA_OFF_ID2 12'h008
`define FMIA_OFF_ID3 12'h00c
`define FMIA_OFF_STAT 12'h010
`define FMIA_OFF_ASEL 12'h020
`define FMIA_OFF_MODE 12'h030
`define FMIA_OFF_OPT 12'h040
// -----------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------
`define FMIA_ASEL_BIT 0
`define FMIA_ASEL_RSVD 7'h00
`define FMIA_ID_RESET 32'h00000000
`define FMIA_OPT_WAIVE_BIT 0
`define FMIA_OPT_BG_BIT 1
// Edges after reset release before the strap sync holds the pin
`define FMIA_STRAP_WAIT 2'd2
// -----------------------------------------------------------------
// Mode entry encodings
// -----------------------------------------------------------------
`define FMIA_MODE_READ 16'h0000
`define FMIA_MODE_CPE 16'h0001
`define FMIA_MODE_DPE 16'h0080
// -----------------------------------------------------------------
// Reserved low window while special areas are selected
// -----------------------------------------------------------------
`define FMIA_RSV_LO 32'h00000000
`define FMIA_RSV_HI 32'h01007fff
`endif

/* core/fmia_top.v */
// Summary of operation
// R01: Area bit gates special area reads
// R02: Area bit set reserves low window
// R03: Area bit resets from boot mode
// R04: Reserved select bits read reset value
// R05: Change area bit only when idle
// R06: Masters avoid reserved window
// R07: Four writable ID words reset zero
// R08: ID words ascend into 128 bits
// R09: Status zero on match, one mismatch
// R10: Reset status reflects stored ID
// R11: Any ID write re-evaluates status
// R12: Authentication gates code P/E, config; the waive option bit passes them on a mismatch
// R13: Mode changes only by software write
// R14: Mode zero: read, no commands
// R15: Mode one: code P/E, data blocked
// R16: Code reads in mode one need background operation
// R17: Mode 80h: data P/E, code readable
`timescale 1ns/1ps
`default_nettype none
`include "fmia_map.vh"
module fmia_top (
   // APB clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Boot strap and stored ID from flash (pins, synchronised)
   input wire boot_serial_mode,
   input wire [127:0] stored_auth_id,
   // Master read request to check
   input wire [31:0] rd_addr,
   input wire rd_is_code,
   input wire rd_is_data,
   input wire rd_is_special,
   // Permissions
   output reg rd_allowed,
   output reg code_read_ok,
   output reg data_read_ok,
   output reg special_read_ok,
   output reg cmd_accept_code,
   output reg cmd_accept_data,
   output reg config_cmd_ok,
   output reg [1:0] seq_mode
);
   // -----------------------------------------------------------------
   // Mode state codes
   // -----------------------------------------------------------------
   localparam [1:0] ST_READ = 2'b00;
   localparam [1:0] ST_CPE = 2'b01;
   localparam [1:0] ST_DPE = 2'b10;

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   reg [31:0] auth_id_word_reg [0:3]; // Entered ID words
   reg config_area_read_enable_reg; // Area select bit
   reg [15:0] mode_entry_register_reg; // Mode entry value
   reg [1:0] mode_reg; // Decoded mode
   reg [1:0] opt_reg; // Waive and background option
   reg strap_done_reg; // Strap captured once
   reg [1:0] strap_wait_reg; // Edges since reset release
   reg boot_s1_reg; // Strap sync stage 1
   reg boot_s2_reg; // Strap sync stage 2
   reg [127:0] sid_s1_reg; // Stored ID sync stage 1
   reg [127:0] sid_s2_reg; // Stored ID sync stage 2
   wire auth_mismatch_flag; // Compare result
   wire [127:0] entered_id;
   wire wr_en;
   wire rd_en;
   reg [1:0] mode_next;
   reg [31:0] rdata_next;
   reg err_next;
   integer i;

   // -----------------------------------------------------------------
   // Address hit helper
   // -----------------------------------------------------------------
   function hit;
      input [11:0] a;
      input [11:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   // -----------------------------------------------------------------
   // Bus strobes
   // -----------------------------------------------------------------
   // Access phase completes in one cycle
   assign wr_en = psel & penable & pwrite & pready;
   assign rd_en = psel & ~penable & ~pwrite;

   // -----------------------------------------------------------------
   // Entered ID assembly
   // -----------------------------------------------------------------
   // Ascending assembly of the 128-bit entered ID
   assign entered_id = {auth_id_word_reg[3], auth_id_word_reg[2],
      auth_id_word_reg[1], auth_id_word_reg[0]}; // R08

   // -----------------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_s1_reg <= 1'b0;
         boot_s2_reg <= 1'b0;
         sid_s1_reg <= 128'h0;
         sid_s2_reg <= 128'h0;
      end else begin
         boot_s1_reg <= boot_serial_mode;
         boot_s2_reg <= boot_s1_reg;
         sid_s1_reg <= stored_auth_id;
         sid_s2_reg <= sid_s1_reg;
      end
   end

   // -----------------------------------------------------------------
   // Compare unit
   // -----------------------------------------------------------------
   fmia_id_cmp #(
      .ID_W(128)
   ) u_cmp (
      .pclk(pclk),
      .presetn(presetn),
      .entered_id(entered_id),
      .stored_id(sid_s2_reg),
      .mismatch_reg(auth_mismatch_flag)
   ); // R09 R10 R11

   // -----------------------------------------------------------------
   // Mode decode from entry value
   // -----------------------------------------------------------------
   always @* begin
      case (pwdata[15:0])
         `FMIA_MODE_READ: mode_next = ST_READ; // R14
         `FMIA_MODE_CPE: mode_next = ST_CPE; // R15
         `FMIA_MODE_DPE: mode_next = ST_DPE; // R17
         default: mode_next = mode_reg; // Unknown value keeps mode
      endcase
   end

   // -----------------------------------------------------------------
   // Register writes
   // -----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (i = 0; i < 4; i = i + 1) begin
            auth_id_word_reg[i] <= `FMIA_ID_RESET; // R07
         end
         config_area_read_enable_reg <= 1'b0;
         strap_done_reg <= 1'b0;
         strap_wait_reg <= 2'd0;
         mode_entry_register_reg <= `FMIA_MODE_READ;
         mode_reg <= ST_READ;
         opt_reg <= 2'b00;
      end else begin
         // Capture boot strap only once both sync stages hold it
         if (strap_wait_reg != `FMIA_STRAP_WAIT) begin
            strap_wait_reg <= strap_wait_reg + 2'd1;
         end else if (!strap_done_reg) begin
            config_area_read_enable_reg <= boot_s2_reg; // R03
            strap_done_reg <= 1'b1;
         end
         if (wr_en) begin
            if (hit(paddr, `FMIA_OFF_ID0)) begin
               auth_id_word_reg[0] <= pwdata; // R07 R11
            end
            if (hit(paddr, `FMIA_OFF_ID1)) begin
               auth_id_word_reg[1] <= pwdata; // R07 R11
            end
            if (hit(paddr, `FMIA_OFF_ID2)) begin
               auth_id_word_reg[2] <= pwdata; // R07 R11
            end
            if (hit(paddr, `FMIA_OFF_ID3)) begin
               auth_id_word_reg[3] <= pwdata; // R07 R11
            end
            if (hit(paddr, `FMIA_OFF_ASEL) && strap_done_reg) begin
               // Reserved bits are not stored
               config_area_read_enable_reg <= pwdata[`FMIA_ASEL_BIT];
            end
            if (hit(paddr, `FMIA_OFF_MODE)) begin
               // Mode changes only here
               mode_entry_register_reg <= pwdata[15:0]; // R13
               mode_reg <= mode_next; // R13
            end
            if (hit(paddr, `FMIA_OFF_OPT)) begin
               opt_reg <= pwdata[1:0];
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // Read mux and unmapped detection
   // -----------------------------------------------------------------
   always @* begin
      rdata_next = 32'h0;
      err_next = 1'b0;
      case (paddr)
         `FMIA_OFF_ID0: rdata_next = auth_id_word_reg[0];
         `FMIA_OFF_ID1: rdata_next = auth_id_word_reg[1];
         `FMIA_OFF_ID2: rdata_next = auth_id_word_reg[2];
         `FMIA_OFF_ID3: rdata_next = auth_id_word_reg[3];
         `FMIA_OFF_STAT: rdata_next = {31'h0, auth_mismatch_flag}; // R10
         `FMIA_OFF_ASEL: begin
            // Upper reserved bits read as reset value
            rdata_next = {24'h0, `FMIA_ASEL_RSVD,
               config_area_read_enable_reg}; // R04
         end
         `FMIA_OFF_MODE: rdata_next = {16'h0, mode_entry_register_reg};
         `FMIA_OFF_OPT: rdata_next = {30'h0, opt_reg};
         default: err_next = 1'b1; // Unmapped
      endcase
   end

   // -----------------------------------------------------------------
   // APB answer: one wait-free access phase
   // -----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & err_next;
         // Read data latched in setup, stands through access
         if (rd_en) begin
            prdata <= rdata_next;
         end
      end
   end

   // -----------------------------------------------------------------
   // Access permissions
   // -----------------------------------------------------------------
   // Waive option lets a locked ID still pass
   wire auth_ok = ~auth_mismatch_flag | opt_reg[`FMIA_OPT_WAIVE_BIT];
   wire in_rsv = config_area_read_enable_reg &&
      (rd_addr <= `FMIA_RSV_HI); // R02
   reg code_ok_c;
   reg data_ok_c;
   always @* begin
      code_ok_c = 1'b1;
      data_ok_c = 1'b1;
      case (mode_reg)
         ST_READ: begin
            code_ok_c = 1'b1; // R14
            data_ok_c = 1'b1; // R14
         end
         ST_CPE: begin
            code_ok_c = opt_reg[`FMIA_OPT_BG_BIT]; // R16
            data_ok_c = 1'b0; // R15
         end
         ST_DPE: begin
            code_ok_c = 1'b1; // R17
            data_ok_c = 1'b0; // R17
         end
         default: begin
            code_ok_c = 1'b1;
            data_ok_c = 1'b1;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // Registered permission outputs
   // -----------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_read_ok <= 1'b1;
         data_read_ok <= 1'b1;
         special_read_ok <= 1'b0;
         cmd_accept_code <= 1'b0;
         cmd_accept_data <= 1'b0;
         config_cmd_ok <= 1'b0;
         rd_allowed <= 1'b0;
         seq_mode <= ST_READ;
      end else begin
         code_read_ok <= code_ok_c;
         data_read_ok <= data_ok_c;
         // Special areas need select bit and authentication, or the waive option
         special_read_ok <= config_area_read_enable_reg & auth_ok; // R01 R12
         cmd_accept_code <= (mode_reg == ST_CPE) & auth_ok; // R12 R14
         cmd_accept_data <= (mode_reg == ST_DPE); // R14
         config_cmd_ok <= (mode_reg == ST_DPE) & auth_ok; // R12
         rd_allowed <= ~in_rsv & // R02
            ~(rd_is_special & ~(config_area_read_enable_reg & auth_ok)) &
            ~(rd_is_code & ~code_ok_c) & ~(rd_is_data & ~data_ok_c); // R01
         seq_mode <= mode_reg;
      end
   end
endmodule // fmia_top
`default_nettype wire

/* verif/fmia_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Bus and mode checks on the top ports
// ----------------------------------------
module fmia_chk (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // Permissions and mode
   input wire logic code_read_ok,
   input wire logic data_read_ok,
   input wire logic cmd_accept_code,
   input wire logic cmd_accept_data,
   input wire logic [1:0] seq_mode
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Address hits a register
   logic hit;
   // Mode entry write completing
   logic mode_wr;
   assign hit = paddr inside {12'h000, 12'h004, 12'h008, 12'h00c,
      12'h010, 12'h020, 12'h030, 12'h040};
   assign mode_wr = psel && penable && pwrite && pready && paddr == 12'h030;
   chk_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   chk_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_err_on_unmapped: assert property (pready |-> pslverr == !hit)
      else $error("error flag does not match address");
   chk_mode_by_write: assert property (
      seq_mode != $past(seq_mode) |-> $past(mode_wr, 2))
      else $error("mode changed without a write");
   chk_read_mode_perm: assert property (
      seq_mode == 2'd0 && $past(seq_mode) == 2'd0 |-> code_read_ok
      && data_read_ok && !cmd_accept_code && !cmd_accept_data)
      else $error("read mode permissions wrong");
   chk_code_pe_perm: assert property (
      seq_mode == 2'd1 && $past(seq_mode) == 2'd1 |-> !data_read_ok
      && !cmd_accept_data)
      else $error("code mode permissions wrong");
   chk_data_pe_perm: assert property (
      seq_mode == 2'd2 && $past(seq_mode) == 2'd2 |-> code_read_ok
      && !data_read_ok && !cmd_accept_code)
      else $error("data mode permissions wrong");
   chk_code_cmd_mode: assert property (
      cmd_accept_code |-> seq_mode == 2'd1 || $past(seq_mode) == 2'd1)
      else $error("code commands outside code mode");
   // Main scenarios reached
   cover property (mode_wr);
   cover property (pready && pslverr);
   cover property (cmd_accept_data);
endmodule // fmia_chk
bind fmia_top fmia_chk i_fmia_chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pready, .pslverr, .code_read_ok, .data_read_ok,
   .cmd_accept_code, .cmd_accept_data, .seq_mode);
`default_nettype wire

/* verif/fmia_rd_master.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Bus master issuing flash reads
// ----------------------------------------
module fmia_rd_master (
   // Clock
   input wire logic pclk,
   // Read wanted by the bench
   input wire logic [31:0] want_addr,
   input wire logic [2:0] want_kind,
   // Read request to the block
   output logic [31:0] rd_addr,
   output logic rd_is_code,
   output logic rd_is_data,
   output logic rd_is_special
);
   // Idle at time zero
   initial {rd_addr, rd_is_special, rd_is_data, rd_is_code} = '0;
   // Idle address toggles to its complement; until the first read that is 0 and all ones, so it enters the reserved window when idle too
   always @(posedge pclk) begin
      rd_addr <= (want_kind != 3'h0) ? want_addr : ~rd_addr;
      {rd_is_special, rd_is_data, rd_is_code} <= want_kind;
   end
endmodule // fmia_rd_master
`default_nettype wire

/* verif/test_flash_mode_id_auth.sv */
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
n_mismatch++; $display("mismatch %s exp %h seen %h", n, e, g); end end
module test_flash_mode_id_auth;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   localparam logic [127:0] SID = 128'h89abcdef_01234567_5a5aa5a5_0f1e2d3c;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd_addr, want_addr = 0, rd_data;
   logic boot_serial_mode = 0, pready, pslverr, rd_err;
   logic [127:0] stored_auth_id = 0;
   logic rd_is_code, rd_is_data, rd_is_special, rd_allowed;
   logic code_read_ok, data_read_ok, special_read_ok, config_cmd_ok;
   logic cmd_accept_code, cmd_accept_data;
   logic [1:0] seq_mode;
   logic [2:0] want_kind = 0;
   int n_mismatch = 0, comparisons = 0;
   // 250 MHz clock
   initial forever #2 pclk = ~pclk;
   fmia_top i_fmia_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .boot_serial_mode,
      .stored_auth_id, .rd_addr, .rd_is_code, .rd_is_data, .rd_is_special,
      .rd_allowed, .code_read_ok, .data_read_ok, .special_read_ok,
      .cmd_accept_code, .cmd_accept_data, .config_cmd_ok, .seq_mode);
   fmia_rd_master i_fmia_rd_master (.pclk, .want_addr, .want_kind,
      .rd_addr, .rd_is_code, .rd_is_data, .rd_is_special);
   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   task finish_test;
      if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // One bus transfer, bounded wait for ready
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      int n;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 0;
      penable <= 0;
      if (n == 20) begin
         n_mismatch++;
         finish_test;
      end
      tick(1);
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      apb(0, a, 0);
      `CK("prdata", e, rd_data)
   endtask
   // Master read then allowed flag
   task automatic rdq(input logic [31:0] a, input logic [2:0] k,
         input logic e);
      want_addr <= a;
      want_kind <= k;
      tick(3);
      `CK("rd_allowed", e, rd_allowed)
   endtask
   task automatic do_reset(input logic boot, input logic [127:0] sid);
      presetn <= 0;
      boot_serial_mode <= boot;
      stored_auth_id <= sid;
      tick(5);
      presetn <= 1;
      tick(4);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_reset;
      do_reset(0, 0);
      rchk(12'h020, 0);
      rchk(12'h010, 0);
      do_reset(1, SID);
      rchk(12'h020, 1);
      rchk(12'h010, 1);
      for (int i = 0; i < 4; i++) rchk(12'(4 * i), 0);
   endtask
   task t_auth;
      for (int i = 0; i < 4; i++) apb(1, 12'(4 * i), SID[96-32*i+:32]);
      rchk(12'h010, 1);
      for (int i = 0; i < 4; i++) apb(1, 12'(4 * i), SID[32*i+:32]);
      rchk(12'h010, 0);
      rchk(12'h00c, SID[127:96]);
      apb(1, 12'h00c, 0);
      rchk(12'h010, 1);
      apb(1, 12'h00c, SID[127:96]);
      rchk(12'h010, 0);
   endtask
   task t_area;
      want_kind <= 0;
      apb(1, 12'h020, 0);
      rdq(32'h01010000, 3'h4, 0);
      `CK("special_ok", 1'b0, special_read_ok)
      want_kind <= 0;
      apb(1, 12'h020, 1);
      rchk(12'h020, 1);
      rdq(32'h01010000, 3'h4, 1);
      rdq(32'h00000100, 3'h1, 0);
      rdq(32'h01007fff, 3'h1, 0);
      rdq(32'h01008000, 3'h1, 1);
   endtask
   task t_mode;
      apb(1, 12'h030, 1);
      tick(2);
      `CK("mode", 2'd1, seq_mode)
      `CK("code_ok", 1'b0, code_read_ok)
      `CK("cmd_code", 1'b1, cmd_accept_code)
      apb(1, 12'h040, 2);
      tick(1);
      `CK("code_ok", 1'b1, code_read_ok)
      apb(1, 12'h000, ~SID[31:0]);
      tick(2);
      `CK("cmd_code", 1'b0, cmd_accept_code)
      `CK("special_ok", 1'b0, special_read_ok)
      apb(1, 12'h040, 1);
      tick(1);
      `CK("cmd_code", 1'b1, cmd_accept_code)
      apb(1, 12'h040, 0);
      apb(1, 12'h030, 5);
      tick(2);
      `CK("mode", 2'd1, seq_mode)
      rchk(12'h030, 5);
      apb(1, 12'h030, 32'h80);
      tick(2);
      `CK("mode", 2'd2, seq_mode)
      `CK("data_ok", 1'b0, data_read_ok)
      `CK("cfg_cmd", 1'b0, config_cmd_ok)
      `CK("cmd_data", 1'b1, cmd_accept_data)
      apb(1, 12'h000, SID[31:0]);
      tick(2);
      `CK("cfg_cmd", 1'b1, config_cmd_ok)
      apb(1, 12'h030, 0);
      tick(2);
      `CK("mode", 2'd0, seq_mode)
      `CK("cmd_data", 1'b0, cmd_accept_data)
      rchk(12'h050, 0);
      `CK("pslverr", 1'b1, rd_err)
   endtask
   initial begin
      t_reset;
      t_auth;
      t_area;
      t_mode;
      finish_test;
   end
endmodule // test_flash_mode_id_auth
`default_nettype wire
